// >>> dss_sequencer.v
/*
 * Start/stop sequencer of a motor frequency drive: command register,
 * eight-state sequencer, halt latches, fault latch and status flags.
 * Assumes a speed ramp that reports zero speed, a power stage that
 * reports readiness and a fault detector giving a fault level, all
 * synchronous to clock. Software reaches two registers over a plain
 * strobe port with read data one cycle after the read strobe.
 */
`include "dss_map.vh"
`default_nettype none

module dss_sequencer
#(
    parameter ADDR_W = `DSS_ADDR_W,
    parameter DATA_W = `DSS_DATA_W
)
(
    input  wire              clock,
    input  wire              rst_b,
    input  wire [ADDR_W-1:0] addr,
    input  wire [DATA_W-1:0] wdata,
    input  wire              wr_stb,
    input  wire              rd_stb,
    output reg  [DATA_W-1:0] rdata,
    input  wire              remote_mode,
    input  wire              reconfig_mode,
    input  wire              power_ready,
    input  wire              fault_detect,
    input  wire              speed_zero,
    output reg  [2:0]        sequencer_state,
    output reg               pwm_enable,
    output reg               ramp_to_zero,
    output reg               quick_halt_rate,
    output reg               inch_speed_ref,
    output reg               fault_latched,
    output reg               fault_free,
    output reg               active_flag,
    output reg               inching_flag,
    output reg               halting_flag,
    output reg               motor_switch_drive,
    output reg               start_permitted,
    output reg               power_stage_ok,
    output reg               run_accepted,
    output reg               entry_pulse,
    output reg               demanded_dir_out
);

    // Command register and derived command levels
    reg  [`DSS_CTL_MSB:0] ctrl;
    wire run_forward_cmd    = ctrl[`DSS_CTL_RUN_FORWARD_CMD];
    wire run_reverse_cmd    = ctrl[`DSS_CTL_RUN_REVERSE_CMD];
    wire run_latch_hold_n   = ctrl[`DSS_CTL_LATCH_N];
    wire inch_cmd           = ctrl[`DSS_CTL_INCH];
    wire operation_permit   = ctrl[`DSS_CTL_PERMIT];
    wire quick_halt_n       = ctrl[`DSS_CTL_QHALT_N];
    wire freewheel_halt_n   = ctrl[`DSS_CTL_FWHALT_N];
    wire remote_dir_invert  = ctrl[`DSS_CTL_DIR_INV];
    wire remote_fault_clear = ctrl[`DSS_CTL_FCLR];
    wire fault_clear_on_run = ctrl[`DSS_CTL_FCLR_RUN];
    wire autorun_at_powerup = ctrl[`DSS_CTL_AUTORUN];

    // Internal state
    reg       run_prev;
    reg       fclr_prev;
    reg       powerup_pending;
    reg       run_latch;
    reg       inch_mode;
    reg       qh_latch;
    reg       fw_latch;
    reg       stop_ramp;
    reg       run_reverse_cmd_dir;

    // Next values
    reg [2:0] next_state;
    reg       next_run_latch;
    reg       next_inch_mode;
    reg       next_stop_ramp;
    reg       next_run_reverse_cmd_dir;
    reg       next_fault_free;

    // Both directions together cancel each other
    wire run_req    = run_forward_cmd ^ run_reverse_cmd;
    wire run_rise   = run_req & ~run_prev;
    wire fclr_rise  = remote_fault_clear & ~fclr_prev;
    wire clear_req  = fclr_rise | (fault_clear_on_run & run_rise);

    // Start trigger: edge normally, level once after reset with autorun
    wire start_trig = run_rise | (autorun_at_powerup & powerup_pending & run_req);

    // Conditions for leaving the disabled states
    wire halts_ok   = quick_halt_n & freewheel_halt_n & ~qh_latch & ~fw_latch;
    wire start_ok   = halts_ok & operation_permit & fault_free & power_ready
                      & remote_mode;

    // Demanded direction, inverted for remote setpoints
    wire dir_now    = run_reverse_cmd_dir ^ remote_dir_invert;

    // Halt latches hold until the motor is at rest again
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            qh_latch <= 1'b0;
            fw_latch <= 1'b0;
        end
        else
        begin
            if (!quick_halt_n && (sequencer_state == `DSS_S_ENABLED))
                qh_latch <= 1'b1;
            else if (quick_halt_n && speed_zero)
                qh_latch <= 1'b0;
            if (!freewheel_halt_n)
                fw_latch <= 1'b1;
            else if (speed_zero)
                fw_latch <= 1'b0;
        end
    end

    // Command register write; set-wins not needed, software owns every bit
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            ctrl <= `DSS_CTL_RESET;
        else if (wr_stb && (addr == `DSS_OFS_CTRL))
            ctrl <= wdata[`DSS_CTL_MSB:0];
    end

    // Sequencer next-state logic
    always @*
    begin
        next_state       = sequencer_state;
        next_run_latch   = run_latch;
        next_inch_mode   = inch_mode;
        next_stop_ramp   = stop_ramp;
        next_run_reverse_cmd_dir = run_reverse_cmd_dir;
        next_fault_free  = fault_free;
        // Fault free drops on a fault, recovers once run and inch are both removed
        if (fault_detect)
            next_fault_free = 1'b0;
        else if (!run_req && !inch_cmd)
            next_fault_free = 1'b1;
        if (run_req)
            next_run_reverse_cmd_dir = run_reverse_cmd;
        case (sequencer_state)
            `DSS_S_NOT_PREP:
            begin
                if (power_ready)
                    next_state = `DSS_S_START_DIS;
            end
            `DSS_S_START_DIS:
            begin
                next_run_latch = 1'b0;
                next_inch_mode = 1'b0;
                if (fault_detect)
                    next_state = `DSS_S_FAULT_ACT;
                else if (halts_ok && fault_free)
                    next_state = `DSS_S_START_EN;
            end
            `DSS_S_START_EN:
            begin
                if (fault_detect)
                    next_state = `DSS_S_FAULT_ACT;
                else if (!halts_ok || !fault_free)
                    next_state = `DSS_S_START_DIS;
                else if (operation_permit && power_ready)
                    next_state = `DSS_S_POWER_STAGE_OK;
            end
            `DSS_S_POWER_STAGE_OK:
            begin
                if (fault_detect)
                    next_state = `DSS_S_FAULT_ACT;
                else if (!halts_ok || !fault_free)
                    next_state = `DSS_S_START_DIS;
                else if (!operation_permit || !power_ready)
                    next_state = `DSS_S_START_EN;
                else if (start_ok && start_trig)
                begin
                    next_state     = `DSS_S_ENABLED;
                    next_run_latch = run_latch_hold_n;
                    next_inch_mode = 1'b0;
                    next_stop_ramp = 1'b0;
                end
                else if (start_ok && inch_cmd && !run_req)
                begin
                    next_state     = `DSS_S_ENABLED;
                    next_inch_mode = 1'b1;
                    next_stop_ramp = 1'b0;
                end
            end
            `DSS_S_ENABLED:
            begin
                if (fault_detect)
                    next_state = `DSS_S_FAULT_ACT;
                else if (!operation_permit || !freewheel_halt_n)
                    next_state = `DSS_S_START_DIS;
                else if (!quick_halt_n)
                    next_state = `DSS_S_QHALT;
                else if (stop_ramp)
                begin
                    // Normal stop: wait for the ramp to reach zero
                    if (speed_zero)
                    begin
                        next_state     = `DSS_S_POWER_STAGE_OK;
                        next_stop_ramp = 1'b0;
                        next_inch_mode = 1'b0;
                    end
                end
                else if (inch_mode)
                begin
                    if (!inch_cmd)
                        next_stop_ramp = 1'b1;
                end
                else
                begin
                    if (!run_latch_hold_n)
                        next_run_latch = 1'b0;
                    if (!run_req && !(run_latch && run_latch_hold_n))
                        next_stop_ramp = 1'b1;
                end
            end
            `DSS_S_QHALT:
            begin
                if (fault_detect)
                    next_state = `DSS_S_FAULT_ACT;
                else if (!operation_permit || !freewheel_halt_n)
                    next_state = `DSS_S_START_DIS;
                else if (speed_zero)
                    next_state = `DSS_S_START_DIS;
            end
            `DSS_S_FAULT_ACT:
            begin
                // Output is off; the fault latches once the motor is at rest
                next_run_latch = 1'b0;
                next_inch_mode = 1'b0;
                next_stop_ramp = 1'b0;
                if (speed_zero)
                    next_state = `DSS_S_FAULT_LATCH;
            end
            `DSS_S_FAULT_LATCH:
            begin
                if (clear_req && !fault_detect)
                    next_state = `DSS_S_START_DIS;
            end
            default:
                next_state = `DSS_S_NOT_PREP;
        endcase
    end

    // State, internal flags and all registered outputs except rdata
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sequencer_state    <= `DSS_S_NOT_PREP;
            run_prev           <= 1'b0;
            fclr_prev          <= 1'b0;
            powerup_pending    <= 1'b1;
            run_latch          <= 1'b0;
            inch_mode          <= 1'b0;
            stop_ramp          <= 1'b0;
            run_reverse_cmd_dir        <= 1'b0;
            fault_free         <= 1'b1;
            pwm_enable         <= 1'b0;
            ramp_to_zero       <= 1'b0;
            quick_halt_rate    <= 1'b0;
            inch_speed_ref     <= 1'b0;
            fault_latched      <= 1'b0;
            active_flag        <= 1'b0;
            inching_flag       <= 1'b0;
            halting_flag       <= 1'b0;
            motor_switch_drive <= 1'b0;
            start_permitted    <= 1'b0;
            power_stage_ok     <= 1'b0;
            run_accepted       <= 1'b0;
            entry_pulse        <= 1'b0;
            demanded_dir_out   <= 1'b0;
        end
        else
        begin
            sequencer_state <= next_state;
            run_prev        <= run_req;
            fclr_prev       <= remote_fault_clear;
            // Autorun chance is used up once the sequencer can first start
            if (sequencer_state == `DSS_S_POWER_STAGE_OK)
                powerup_pending <= 1'b0;
            run_latch       <= next_run_latch;
            inch_mode       <= next_inch_mode;
            stop_ramp       <= next_stop_ramp;
            run_reverse_cmd_dir     <= next_run_reverse_cmd_dir;
            fault_free      <= next_fault_free;
            // Drive stage and ramp control
            pwm_enable      <= (next_state == `DSS_S_ENABLED)
                               || (next_state == `DSS_S_QHALT);
            ramp_to_zero    <= ((next_state == `DSS_S_ENABLED) && next_stop_ramp)
                               || (next_state == `DSS_S_QHALT);
            quick_halt_rate <= (next_state == `DSS_S_QHALT);
            inch_speed_ref  <= (next_state == `DSS_S_ENABLED) && next_inch_mode;
            // Status flags
            fault_latched   <= (next_state == `DSS_S_FAULT_ACT)
                               || (next_state == `DSS_S_FAULT_LATCH);
            active_flag     <= (next_state == `DSS_S_ENABLED);
            inching_flag    <= (next_state == `DSS_S_ENABLED) && next_inch_mode;
            halting_flag    <= ((next_state == `DSS_S_ENABLED) && next_stop_ramp)
                               || (next_state == `DSS_S_QHALT)
                               || (next_state == `DSS_S_FAULT_ACT);
            // Switch opens on fault or while reconfiguring
            motor_switch_drive <= (next_state != `DSS_S_FAULT_ACT)
                                  && (next_state != `DSS_S_FAULT_LATCH)
                                  && !reconfig_mode;
            // Start-permitted flag tracks the exact start condition
            start_permitted <= (next_state == `DSS_S_POWER_STAGE_OK)
                               && halts_ok && operation_permit
                               && next_fault_free && power_ready
                               && remote_mode;
            power_stage_ok  <= (next_state == `DSS_S_POWER_STAGE_OK)
                               || (next_state == `DSS_S_ENABLED)
                               || (next_state == `DSS_S_QHALT);
            run_accepted    <= (next_state == `DSS_S_ENABLED) && !next_inch_mode
                               && !next_stop_ramp;
            // One cycle on entry into running or inching
            entry_pulse     <= (next_state == `DSS_S_ENABLED)
                               && (sequencer_state != `DSS_S_ENABLED);
            demanded_dir_out <= dir_now;
        end
    end

    // Register read: data valid the cycle after the strobe only
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= {DATA_W{1'b0}};
        else if (rd_stb && (addr == `DSS_OFS_CTRL))
            rdata <= {{(DATA_W-`DSS_CTL_MSB-1){1'b0}}, ctrl};
        else if (rd_stb && (addr == `DSS_OFS_STAT))
        begin
            rdata <= {DATA_W{1'b0}};
            rdata[`DSS_ST_STATE_MSB:`DSS_ST_STATE_LSB] <= sequencer_state;
            rdata[`DSS_ST_FLATCH]   <= fault_latched;
            rdata[`DSS_ST_FFREE]    <= fault_free;
            rdata[`DSS_ST_ACTIVE]   <= active_flag;
            rdata[`DSS_ST_INCH]     <= inching_flag;
            rdata[`DSS_ST_HALTING]  <= halting_flag;
            rdata[`DSS_ST_SWITCH]   <= motor_switch_drive;
            rdata[`DSS_ST_START_OK] <= start_permitted;
            rdata[`DSS_ST_PWR_OK]   <= power_stage_ok;
            rdata[`DSS_ST_ACCEPT]   <= run_accepted;
            rdata[`DSS_ST_DIR]      <= demanded_dir_out;
        end
        else
            rdata <= {DATA_W{1'b0}};                                // Unmapped or idle reads zero
    end

endmodule

`default_nettype wire

// >>> dss_map.vh
/*
 * Register map, field positions, reset values and state codes of the
 * drive start/stop sequencer.
 * Assumes inclusion by the sequencer only, one word per register.
 */
`ifndef DSS_MAP_VH
`define DSS_MAP_VH

`define DSS_ADDR_W          4
`define DSS_DATA_W          16

// Register offsets
`define DSS_OFS_CTRL        4'h0
`define DSS_OFS_STAT        4'h4

// Command register fields
`define DSS_CTL_RUN_FORWARD_CMD     0
`define DSS_CTL_RUN_REVERSE_CMD     1
`define DSS_CTL_LATCH_N     2
`define DSS_CTL_INCH        3
`define DSS_CTL_PERMIT      4
`define DSS_CTL_QHALT_N     5
`define DSS_CTL_FWHALT_N    6
`define DSS_CTL_DIR_INV     7
`define DSS_CTL_FCLR        8
`define DSS_CTL_FCLR_RUN    9
`define DSS_CTL_AUTORUN     10
`define DSS_CTL_MSB         10
`define DSS_CTL_RESET       11'h270

// Status register fields
`define DSS_ST_STATE_LSB    0
`define DSS_ST_STATE_MSB    2
`define DSS_ST_FLATCH       3
`define DSS_ST_FFREE        4
`define DSS_ST_ACTIVE       5
`define DSS_ST_INCH         6
`define DSS_ST_HALTING      7
`define DSS_ST_SWITCH       8
`define DSS_ST_START_OK     9
`define DSS_ST_PWR_OK       10
`define DSS_ST_ACCEPT       11
`define DSS_ST_DIR          12

// Sequencer state codes
`define DSS_S_NOT_PREP      3'h0
`define DSS_S_START_DIS     3'h1
`define DSS_S_START_EN      3'h2
`define DSS_S_POWER_STAGE_OK   3'h3
`define DSS_S_ENABLED       3'h4
`define DSS_S_QHALT         3'h5
`define DSS_S_FAULT_ACT     3'h6
`define DSS_S_FAULT_LATCH   3'h7

`endif

// >>> dss_sequencer_end.v
/*
 * Companion of the sequencer source; it holds no logic, all of which
 * lives in dss_sequencer.v.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
`default_nettype wire

// >>> dss_far_model.sv
/* Far-side model: speed ramp, power stage and fault detector.
   Assumes the bench drives fault_inject and hold_off after a clock edge. */
`default_nettype none
module dss_far_model
#(
    parameter logic [3:0] TOP_SPEED = 4'hc
)
(
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic pwm_enable,
    input  wire logic ramp_to_zero,
    input  wire logic fault_inject,
    input  wire logic hold_off,
    output logic      power_ready,
    output logic      fault_detect,
    output logic      speed_zero
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] speed;
    // Speed climbs while driven, decays on a ramp stop or freewheel
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            speed <= 4'h0;
        else if (pwm_enable && !ramp_to_zero && speed != TOP_SPEED)
            speed <= speed + 4'h1;
        else if ((!pwm_enable || ramp_to_zero) && speed != 4'h0)
            speed <= speed - 4'h1;
    end
    // Power and fault levels come straight from the bench controls
    assign power_ready  = !hold_off;
    assign fault_detect = fault_inject;
    assign speed_zero   = (speed == 4'h0);
endmodule
`default_nettype wire

// >>> dss_sequencer_chk.sv
/* Port checker for the start/stop sequencer.
   Assumes one clock domain and the sequencer's port names. */
`default_nettype none
module dss_sequencer_chk
(
    input wire logic       clock,
    input wire logic       rst_b,
    input wire logic       reconfig_mode,
    input wire logic       power_ready,
    input wire logic       fault_detect,
    input wire logic       speed_zero,
    input wire logic [2:0] sequencer_state,
    input wire logic       fault_latched,
    input wire logic       active_flag,
    input wire logic       inching_flag,
    input wire logic       motor_switch_drive,
    input wire logic       power_stage_ok,
    input wire logic       run_accepted,
    input wire logic       entry_pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    // Flags decoded from the state code
    AST_FLATCH: assert property (fault_latched == (sequencer_state >= 3'h6))
        else $error("fault flag disagrees with state");
    AST_ACTIVE: assert property (active_flag == (sequencer_state == 3'h4))
        else $error("active flag disagrees with state");
    AST_PWR_OK: assert property (power_stage_ok == (sequencer_state inside {3'h3, 3'h4, 3'h5}))
        else $error("power stage flag disagrees with state");
    AST_ACCEPT: assert property (run_accepted |-> active_flag && !inching_flag)
        else $error("run accepted outside running");
    // Entry pulse only on the first cycle of the enabled state
    AST_ENTRY: assert property (
        entry_pulse |-> (active_flag && $past(sequencer_state) != 3'h4) ##1 !entry_pulse)
        else $error("entry pulse misplaced or too long");
    // Both sides of the check guard against a one-cycle state lag
    AST_SWITCH: assert property (
        (fault_latched && $past(fault_latched)) || $past(reconfig_mode) |-> !motor_switch_drive)
        else $error("motor switch closed during fault or reconfig");
    AST_FAULT_IN: assert property (
        fault_detect && sequencer_state inside {[3'h1:3'h5]} |=> sequencer_state == 3'h6)
        else $error("fault did not enter fault active");
    AST_TRIP_STOP: assert property (sequencer_state == 3'h6 && speed_zero |=> sequencer_state == 3'h7)
        else $error("fault active did not latch at zero speed");
    AST_QH_END: assert property (
        sequencer_state == 3'h5 && speed_zero && !fault_detect |=> sequencer_state == 3'h1)
        else $error("quick halt did not end at zero speed");
    AST_POWER_UP: assert property (sequencer_state == 3'h0 && power_ready |=> sequencer_state == 3'h1)
        else $error("not prepared state did not advance");
    AST_INTO_RUN: assert property ($rose(active_flag) |-> $past(sequencer_state) == 3'h3)
        else $error("enabled entered from wrong state");
    COV_INCH: cover property (entry_pulse && inching_flag);
    COV_QHALT: cover property (sequencer_state == 3'h5);
    COV_TRIP: cover property (sequencer_state == 3'h7);
endmodule
bind dss_sequencer dss_sequencer_chk u_chk
(
    .clock, .rst_b, .reconfig_mode, .power_ready, .fault_detect, .speed_zero, .sequencer_state,
    .fault_latched, .active_flag, .inching_flag, .motor_switch_drive, .power_stage_ok,
    .run_accepted, .entry_pulse
);
`default_nettype wire

// >>> tb.sv
/* Self-checking bench for the start/stop sequencer and its far-side model.
   Assumes the checker is bound to the sequencer by its own file. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] BASE = 16'h0270;
    logic        clock         = 1'b0;
    logic        rst_b         = 1'b0;
    logic [3:0]  addr          = 4'h0;
    logic [15:0] wdata         = 16'h0000;
    logic        wr_stb        = 1'b0;
    logic        rd_stb        = 1'b0;
    logic        remote_mode   = 1'b1;
    logic        reconfig_mode = 1'b0;
    logic        fault_inject  = 1'b0;
    logic        hold_off      = 1'b0;
    logic [15:0] rd_val;
    int          fails         = 0;
    int          num_checks    = 0;
    wire  [15:0] rdata;
    wire  [2:0]  sequencer_state;
    wire         power_ready, fault_detect, speed_zero, pwm_enable, ramp_to_zero, quick_halt_rate;
    wire         inching_flag, halting_flag, motor_switch_drive, run_accepted, demanded_dir_out;
    wire         inch_speed_ref, fault_free, start_permitted;
    // 125 MHz clock
    always #4 clock = ~clock;
    dss_sequencer dut
    (
        .clock, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .remote_mode, .reconfig_mode,
        .power_ready, .fault_detect, .speed_zero, .sequencer_state, .pwm_enable, .ramp_to_zero,
        .quick_halt_rate, .inch_speed_ref, .fault_latched(), .fault_free, .active_flag(),
        .inching_flag, .halting_flag, .motor_switch_drive, .start_permitted, .power_stage_ok(),
        .run_accepted, .entry_pulse(), .demanded_dir_out
    );
    dss_far_model far
    (
        .clock, .rst_b, .pwm_enable, .ramp_to_zero, .fault_inject, .hold_off,
        .power_ready, .fault_detect, .speed_zero
    );
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Leading edge keeps two strobes from landing in one time step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 rd_val = rdata;
    endtask
    // Polled mid-cycle so the edge's updates have landed
    task automatic ws(input logic [2:0] e);
        int n;
        for (n = 0; n < 300 && sequencer_state !== e; n++)
            @(negedge clock);
        chk(16'(sequencer_state), 16'(e));
        if (n == 300)
            tally_and_finish();
    endtask
    // Outputs settle two edges after the write strobe
    task automatic sc(input logic [2:0] e);
        repeat (2) @(negedge clock);
        chk(16'(sequencer_state), 16'(e));
    endtask
    task automatic run_up(input logic [15:0] d);
        wr(4'h0, d);
        ws(3'h4);
        repeat (12) @(negedge clock);
    endtask
    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
    endtask
    task automatic t_regs();
        rd(4'h0);
        chk(rd_val, BASE);
        wr(4'h4, 16'hffff);
        rd(4'h8);
        chk(rd_val, 16'h0000);
        ws(3'h3);
        chk(16'(start_permitted), 16'h0001);
        rd(4'h4);
        chk(rd_val & 16'h1fff, 16'h0713);
    endtask
    task automatic t_remote();
        @(posedge clock) remote_mode <= 1'b0;
        wr(4'h0, BASE | 16'h0001);
        sc(3'h3);
        chk(16'(start_permitted), 16'h0000);
        wr(4'h0, BASE);
        @(posedge clock) remote_mode <= 1'b1;
        run_up(BASE | 16'h0001);
        chk(16'(demanded_dir_out), 16'h0000);
        chk(16'(run_accepted), 16'h0001);
        wr(4'h0, BASE);
        ws(3'h3);
    endtask
    task automatic t_dir();
        run_up(BASE | 16'h0002);
        chk(16'(demanded_dir_out), 16'h0001);
        wr(4'h0, BASE | 16'h0082);
        sc(3'h4);
        chk(16'(demanded_dir_out), 16'h0000);
        wr(4'h0, BASE | 16'h0083);
        ws(3'h3);
        wr(4'h0, BASE);
    endtask
    task automatic t_latch_inch();
        run_up(BASE | 16'h0005);
        wr(4'h0, BASE | 16'h0004);
        sc(3'h4);
        chk(16'(run_accepted), 16'h0001);
        wr(4'h0, BASE);
        ws(3'h3);
        wr(4'h0, BASE | 16'h0008);
        ws(3'h4);
        chk(16'(inching_flag), 16'h0001);
        chk(16'(inch_speed_ref), 16'h0001);
        wr(4'h0, BASE);
        sc(3'h4);
        chk(16'(halting_flag), 16'h0001);
        chk(16'(ramp_to_zero), 16'h0001);
        ws(3'h3);
    endtask
    task automatic t_halts();
        run_up(BASE | 16'h0001);
        wr(4'h0, 16'h0261);
        sc(3'h1);
        chk(16'(pwm_enable), 16'h0000);
        sc(3'h2);
        wr(4'h0, BASE);
        ws(3'h3);
        run_up(BASE | 16'h0001);
        wr(4'h0, 16'h0251);
        sc(3'h5);
        chk(16'(quick_halt_rate), 16'h0001);
        ws(3'h1);
        wr(4'h0, BASE);
        ws(3'h3);
        run_up(BASE | 16'h0001);
        wr(4'h0, 16'h0231);
        sc(3'h1);
        wr(4'h0, 16'h0271);
        sc(3'h1);
        wr(4'h0, BASE);
        ws(3'h3);
    endtask
    task automatic t_fault();
        run_up(BASE | 16'h0001);
        @(posedge clock) fault_inject <= 1'b1;
        ws(3'h6);
        chk(16'(motor_switch_drive), 16'h0000);
        @(posedge clock) fault_inject <= 1'b0;
        ws(3'h7);
        chk(16'(fault_free), 16'h0000);
        rd(4'h4);
        chk(rd_val & 16'h0118, 16'h0008);
        wr(4'h0, BASE | 16'h0101);
        sc(3'h1);
        wr(4'h0, BASE);
        ws(3'h3);
    endtask
    task automatic t_fault_run();
        run_up(BASE | 16'h0001);
        @(posedge clock) fault_inject <= 1'b1;
        ws(3'h6);
        @(posedge clock) fault_inject <= 1'b0;
        wr(4'h0, BASE);
        ws(3'h7);
        wr(4'h0, BASE | 16'h0001);
        sc(3'h1);
        wr(4'h0, BASE);
        ws(3'h3);
    endtask
    task automatic t_autorun();
        for (int a = 0; a < 2; a++)
        begin
            @(posedge clock) hold_off <= 1'b1;
            do_reset();
            wr(4'h0, BASE | 16'h0001 | (a ? 16'h0400 : 16'h0000));
            sc(3'h0);
            @(posedge clock) hold_off <= 1'b0;
            repeat (12) @(negedge clock);
            chk(16'(sequencer_state), 16'(3 + a));
            wr(4'h0, BASE);
        end
        ws(3'h3);
        @(posedge clock) reconfig_mode <= 1'b1;
        repeat (2) @(negedge clock);
        chk(16'(motor_switch_drive), 16'h0000);
        @(posedge clock) reconfig_mode <= 1'b0;
        repeat (2) @(negedge clock);
        chk(16'(motor_switch_drive), 16'h0001);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        do_reset();
        t_regs();
        t_remote();
        t_dir();
        t_latch_inch();
        t_halts();
        t_fault();
        t_fault_run();
        t_autorun();
        tally_and_finish();
    end
endmodule
`default_nettype wire
